// ---- verilog/csfd_pkg.sv ----
// Package for the card-specific field encoder: offsets, layouts, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
package csfd_pkg;

  localparam int ADDR_W = 12;
  localparam int IMAGE_W = 81;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TIMING = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_POWER = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_DRIVER = 12'h010;

  // Code limits and fixed values
  localparam logic [1:0] STRUCT_EXT = 2'h3;
  localparam logic [3:0] SPEC_V4 = 4'h4;
  localparam logic [3:0] SPEC_FIRST_RSVD = 4'h5;
  localparam logic [3:0] SIZE_FACTOR_RSVD = 4'h0;
  localparam logic [2:0] FREQ_FIRST_RSVD = 3'h4;
  localparam logic [3:0] BLEN_FIRST_RSVD = 4'hC;
  localparam logic [7:0] RATE_V4 = 8'h2A;

  // Access-time or transfer-rate byte
  typedef struct packed {
    logic reserved;
    logic [3:0] multiplier;
    logic [2:0] unit;
  } csfd_rate_t;

  // Word at OFS_TIMING
  typedef struct packed {
    csfd_rate_t transfer_rate;
    logic [7:0] clocked_access_cycles;
    csfd_rate_t async_access_time;
    logic [1:0] reserved;
    logic [3:0] spec_version;
    logic [1:0] structure_version_code;
  } csfd_timing_t;

  // Word at OFS_FORMAT
  typedef struct packed {
    logic [7:0] reserved;
    logic [3:0] write_block_bytes_exp;
    logic driver_stage_present;
    logic read_boundary_cross_ok;
    logic write_boundary_cross_ok;
    logic partial_read_allowed;
    logic [3:0] read_block_bytes_exp;
    logic [11:0] command_class_mask;
  } csfd_format_t;

  // Word at OFS_POWER
  typedef struct packed {
    logic [4:0] reserved;
    logic [2:0] device_size_scale;
    logic [2:0] write_current_high_supply;
    logic [2:0] write_current_low_supply;
    logic [2:0] read_current_high_supply;
    logic [2:0] read_current_low_supply;
    logic [11:0] device_size;
  } csfd_power_t;

  // Code check results, word at OFS_STATUS
  typedef struct packed {
    logic [22:0] reserved;
    logic currents_apply;
    logic rate_forced;
    logic wblen_rsvd;
    logic blen_rsvd;
    logic rate_size_factor_rsvd;
    logic rate_unit_rsvd;
    logic async_size_factor_rsvd;
    logic spec_rsvd;
    logic struct_ext;
  } csfd_status_t;

  // Register image, bit 80 is the top bit of the card register
  typedef struct packed {
    logic [1:0] structure_version_code;
    logic [3:0] spec_version;
    logic [1:0] rsvd_a;
    csfd_rate_t async_access_time;
    logic [7:0] clocked_access_cycles;
    csfd_rate_t transfer_rate;
    logic [11:0] command_class_mask;
    logic [3:0] read_block_bytes_exp;
    logic partial_read_allowed;
    logic write_boundary_cross_ok;
    logic read_boundary_cross_ok;
    logic driver_stage_present;
    logic [1:0] rsvd_b;
    logic [11:0] device_size;
    logic [2:0] read_current_low_supply;
    logic [2:0] read_current_high_supply;
    logic [2:0] write_current_low_supply;
    logic [2:0] write_current_high_supply;
    logic [2:0] device_size_scale;
  } csfd_image_t;

  // Reset values: structure 1.2, spec 4.x, 1.5 ms, 100 cycles, 20 MHz,
  // classes 0,2,4-7, 512-byte blocks, 60 mA / 80 mA
  localparam csfd_timing_t TIMING_RST = 32'h2A01_2612;
  localparam csfd_format_t FORMAT_RST = 32'h0090_90F5;
  localparam csfd_power_t POWER_RST = 32'h00DB_6000;
  localparam logic [15:0] DRIVER_RST = 16'h0404;

endpackage : csfd_pkg

// ---- verilog/csfd_code_check.sv ----
// Flags reserved or substituted codes in the written field words.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module csfd_code_check (
  // Field words
  input wire csfd_pkg::csfd_timing_t timing,
  input wire csfd_pkg::csfd_format_t format,
  // Mode
  input wire logic hs_mode,
  // Result
  output csfd_pkg::csfd_status_t status
);

  always_comb begin
    status = '0;
    status.struct_ext = timing.structure_version_code
      == csfd_pkg::STRUCT_EXT;
    status.spec_rsvd = timing.spec_version
      >= csfd_pkg::SPEC_FIRST_RSVD;
    status.async_size_factor_rsvd = timing.async_access_time.multiplier
      == csfd_pkg::SIZE_FACTOR_RSVD;
    status.rate_unit_rsvd = timing.transfer_rate.unit
      >= csfd_pkg::FREQ_FIRST_RSVD;
    status.rate_size_factor_rsvd = timing.transfer_rate.multiplier
      == csfd_pkg::SIZE_FACTOR_RSVD;
    status.blen_rsvd = format.read_block_bytes_exp
      >= csfd_pkg::BLEN_FIRST_RSVD;
    status.wblen_rsvd = format.write_block_bytes_exp
      >= csfd_pkg::BLEN_FIRST_RSVD;
    status.rate_forced = (timing.spec_version >= csfd_pkg::SPEC_V4)
      && (timing.transfer_rate != csfd_pkg::RATE_V4);
    status.currents_apply = !hs_mode;
  end

endmodule : csfd_code_check

// ---- verilog/csfd_encoder.sv ----
// Card-specific field encoder: APB-programmed fields packed into the
// top 81 bits of the card register image, with code checks.
// Assumes an APB master on clk_sys and a synchronous hs_mode level.
//
// What this block does
// - Structure code 0..2, 3 means extended
// - Spec code 0..4, 5..15 reserved
// - Access-time unit in bits 2:0, bit7 reserved
// - Access-time multiplier bits 6:3, zero reserved
// - Clocked access byte counts hundreds of cycles
// - Spec 4 or later reports rate 0x2A
// - Rate unit bits 2:0, 4..7 reserved
// - Rate multiplier bits 6:3, zero reserved
// - Class mask bit n means class n
// - Block length is two to code, 12+ reserved
// - Partial read flag permits smaller blocks
// - Write crossing flag permits boundary spans
// - Read crossing flag permits boundary spans
// - Driver flag set only with driver register
// - Size scale code gives factor two^(code+2)
// - Low-supply current codes, three bits
// - High-supply current codes, three bits
// - Current codes valid outside high-speed only
// - Fields are binary, leftmost bit most significant
`timescale 1ns/1ps
module csfd_encoder (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csfd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Card side
  input wire logic hs_mode,
  output csfd_pkg::csfd_image_t card_specific_register,
  output logic driver_stage_present,
  output logic [15:0] driver_stage
);

  ////////////////////////////////////////////////////////////////////////
  // Storage

  csfd_pkg::csfd_timing_t timing_q;
  csfd_pkg::csfd_format_t format_q;
  csfd_pkg::csfd_power_t power_q;
  csfd_pkg::csfd_status_t status_d;
  csfd_pkg::csfd_status_t status_q;
  csfd_pkg::csfd_image_t image_d;
  csfd_pkg::csfd_image_t image_q;
  logic [15:0] driver_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic pready_q;
  logic pslverr_q;
  logic mapped_d;
  logic access;
  logic wr_en;
  logic rd_take;

  ////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, answer on the second access cycle

  assign access = psel && penable;
  assign rd_take = access && !pready_q;
  assign wr_en = access && pready_q && pwrite;

  always_comb begin
    mapped_d = 1'b1;
    rdata_d = '0;
    case (paddr)
      csfd_pkg::OFS_TIMING: rdata_d = timing_q;
      csfd_pkg::OFS_FORMAT: rdata_d = format_q;
      csfd_pkg::OFS_POWER: rdata_d = power_q;
      csfd_pkg::OFS_STATUS: rdata_d = status_q;
      // Reads as zero when no driver stage exists
      csfd_pkg::OFS_DRIVER: begin
        rdata_d = format_q.driver_stage_present
          ? {16'h0000, driver_q} : 32'h0000_0000;
      end
      default: begin
        mapped_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= rd_take;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (rd_take) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr_q <= !mapped_d;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field registers, reserved bits forced to zero

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timing_q <= csfd_pkg::TIMING_RST;
    end else if (wr_en && paddr == csfd_pkg::OFS_TIMING) begin
      timing_q <= pwdata;
      timing_q.reserved <= '0;
      timing_q.async_access_time.reserved <= 1'b0;
      timing_q.transfer_rate.reserved <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      format_q <= csfd_pkg::FORMAT_RST;
    end else if (wr_en && paddr == csfd_pkg::OFS_FORMAT) begin
      format_q <= pwdata;
      format_q.reserved <= '0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_q <= csfd_pkg::POWER_RST;
    end else if (wr_en && paddr == csfd_pkg::OFS_POWER) begin
      power_q <= pwdata;
      power_q.reserved <= '0;
    end
  end

  // Driver stage register exists only while the flag is set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      driver_q <= csfd_pkg::DRIVER_RST;
    end else if (wr_en && paddr == csfd_pkg::OFS_DRIVER
                 && format_q.driver_stage_present) begin
      driver_q <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code checks

  csfd_code_check u_check (
    .timing(timing_q),
    .format(format_q),
    .hs_mode(hs_mode),
    .status(status_d)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Image packing, most significant field at the top

  always_comb begin
    image_d = '0;
    image_d.structure_version_code = timing_q.structure_version_code;
    image_d.spec_version = timing_q.spec_version;
    image_d.async_access_time.unit =
      timing_q.async_access_time.unit;
    image_d.async_access_time.multiplier =
      timing_q.async_access_time.multiplier;
    image_d.clocked_access_cycles = timing_q.clocked_access_cycles;
    image_d.transfer_rate.unit = timing_q.transfer_rate.unit;
    image_d.transfer_rate.multiplier =
      timing_q.transfer_rate.multiplier;
    if (timing_q.spec_version >= csfd_pkg::SPEC_V4) begin
      image_d.transfer_rate = csfd_pkg::RATE_V4;
    end
    image_d.command_class_mask = format_q.command_class_mask;
    image_d.read_block_bytes_exp = format_q.read_block_bytes_exp;
    image_d.partial_read_allowed = format_q.partial_read_allowed;
    image_d.write_boundary_cross_ok =
      format_q.write_boundary_cross_ok;
    image_d.read_boundary_cross_ok = format_q.read_boundary_cross_ok;
    image_d.driver_stage_present = format_q.driver_stage_present;
    image_d.device_size = power_q.device_size;
    image_d.read_current_low_supply =
      power_q.read_current_low_supply;
    image_d.write_current_low_supply =
      power_q.write_current_low_supply;
    image_d.read_current_high_supply =
      power_q.read_current_high_supply;
    image_d.write_current_high_supply =
      power_q.write_current_high_supply;
    image_d.device_size_scale = power_q.device_size_scale;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      image_q <= '0;
    end else begin
      image_q <= image_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign card_specific_register = image_q;
  assign driver_stage_present = image_q.driver_stage_present;
  assign driver_stage = driver_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  // Image and status hold reset zeros until the first edge after release
  logic image_live_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      image_live_q <= 1'b0;
    end else begin
      image_live_q <= 1'b1;
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_dsr_write_absent;
    psel && penable && pready_q && pwrite
      && paddr == csfd_pkg::OFS_DRIVER && !format_q.driver_stage_present;
  endsequence

  property p_apb_answer;
    @(posedge clk_sys) disable iff (!resetn)
      s_setup ##1 (psel && penable) |=> pready_q;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("pready not raised after one wait cycle");

  property p_rate_v4;
    @(posedge clk_sys) disable iff (!resetn)
      image_q.spec_version >= csfd_pkg::SPEC_V4
        |-> image_q.transfer_rate == csfd_pkg::RATE_V4;
  endproperty
  a_rate_v4: assert property (p_rate_v4)
    else $error("rate byte not 0x2A for spec 4 or later");

  property p_async_rsvd_bit;
    @(posedge clk_sys) disable iff (!resetn)
      image_q.async_access_time.reserved == 1'b0;
  endproperty
  a_async_rsvd_bit: assert property (p_async_rsvd_bit)
    else $error("access-time reserved bit set");

  property p_rate_rsvd_bit;
    @(posedge clk_sys) disable iff (!resetn)
      image_q.transfer_rate.reserved == 1'b0;
  endproperty
  a_rate_rsvd_bit: assert property (p_rate_rsvd_bit)
    else $error("rate reserved bit set");

  property p_struct_ext;
    @(posedge clk_sys) disable iff (!resetn)
      status_q.struct_ext
        == (image_q.structure_version_code == csfd_pkg::STRUCT_EXT);
  endproperty
  a_struct_ext: assert property (p_struct_ext)
    else $error("structure extended flag disagrees with image");

  property p_spec_rsvd;
    @(posedge clk_sys) disable iff (!resetn)
      status_q.spec_rsvd
        == (image_q.spec_version >= csfd_pkg::SPEC_FIRST_RSVD);
  endproperty
  a_spec_rsvd: assert property (p_spec_rsvd)
    else $error("spec reserved flag disagrees with image");

  property p_async_size_factor;
    @(posedge clk_sys) disable iff (!resetn)
      image_live_q |-> status_q.async_size_factor_rsvd
        == (image_q.async_access_time.multiplier == csfd_pkg::SIZE_FACTOR_RSVD);
  endproperty
  a_async_size_factor: assert property (p_async_size_factor)
    else $error("access-time multiplier flag wrong");

  property p_blen_rsvd;
    @(posedge clk_sys) disable iff (!resetn)
      status_q.blen_rsvd
        == (image_q.read_block_bytes_exp >= csfd_pkg::BLEN_FIRST_RSVD);
  endproperty
  a_blen_rsvd: assert property (p_blen_rsvd)
    else $error("block length reserved flag wrong");

  property p_dsr_absent;
    @(posedge clk_sys) disable iff (!resetn)
      s_dsr_write_absent |=> $stable(driver_q);
  endproperty
  a_dsr_absent: assert property (p_dsr_absent)
    else $error("driver register written while absent");

  property p_currents;
    @(posedge clk_sys) disable iff (!resetn)
      hs_mode |=> !status_q.currents_apply;
  endproperty
  a_currents: assert property (p_currents)
    else $error("currents marked valid in high-speed mode");

endmodule : csfd_encoder

// ---- tb/csfd_host_model.sv ----
// Host-side decoder of the card register image, as the far side reads it.
// Assumes the image port of the encoder; purely combinational.
`timescale 1ns/1ps
module csfd_host_model (
  // Card register image
  input wire csfd_pkg::csfd_image_t image,
  input wire logic hs_mode,
  // Decoded results
  output logic code_ok,
  output logic [63:0] capacity,
  output logic [31:0] nac_cycles,
  output logic currents_valid
);
  always_comb begin
    // Reserved codes make the image unusable
    code_ok = image.structure_version_code != csfd_pkg::STRUCT_EXT
      && image.spec_version < csfd_pkg::SPEC_FIRST_RSVD
      && image.async_access_time.multiplier != csfd_pkg::SIZE_FACTOR_RSVD
      && image.transfer_rate.multiplier != csfd_pkg::SIZE_FACTOR_RSVD
      && image.transfer_rate.unit < csfd_pkg::FREQ_FIRST_RSVD
      && image.read_block_bytes_exp < csfd_pkg::BLEN_FIRST_RSVD;
    capacity = '0;
    if (code_ok) begin
      capacity = ((64'(image.device_size) + 64'h1)
        << (int'(image.device_size_scale) + 2))
        << image.read_block_bytes_exp;
    end
    // Typical clocked part only, not a worst case
    nac_cycles = 32'(image.clocked_access_cycles) * 32'h64;
    currents_valid = !hs_mode;
  end
endmodule : csfd_host_model

// ---- tb/tb.sv ----
// Self-checking bench for the card-specific field encoder.
// Drives APB on clk_sys; expected read results queue for a monitor.
`timescale 1ns/1ps
module tb;
  logic clk_sys, resetn, psel, penable, pwrite, hs_mode;
  logic [csfd_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, w, t, f, p, nac;
  logic pready, pslverr, drv_present, code_ok, cur_valid;
  logic [15:0] drv_stage, drv_exp;
  logic [63:0] capacity;
  csfd_pkg::csfd_image_t img;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int failures, samples_checked, seed, i;
  localparam logic [31:0] TMASK = 32'h7FFF_7F3F;

  csfd_encoder i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hs_mode(hs_mode), .card_specific_register(img),
    .driver_stage_present(drv_present), .driver_stage(drv_stage));
  csfd_host_model i_host (.image(img), .hs_mode(hs_mode),
    .code_ok(code_ok), .capacity(capacity), .nac_cycles(nac),
    .currents_valid(cur_valid));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(logic [63:0] got, logic [63:0] ex);
    samples_checked++;
    if (got !== ex) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, ex);
    end
  endtask : chk

  // Image follows a write exactly one edge later
  task automatic cmp_img(csfd_pkg::csfd_image_t ex);
    @(posedge clk_sys);
    #1;
    samples_checked++;
    if (img !== ex) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, img, ex);
    end
  endtask : cmp_img

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic err,
                     logic cd, logic [31:0] ex);
    int n;
    exp_q.push_back({cd, err, ex});
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      complete_run();
    end
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 1'b0, '0);
  endtask : wr

  task automatic rd(logic [11:0] a, logic [31:0] ex);
    apb(1'b0, a, '0, 1'b0, 1'b1, ex);
  endtask : rd

  function automatic csfd_pkg::csfd_image_t exp_img(logic [31:0] t,
      logic [31:0] f, logic [31:0] p);
    csfd_pkg::csfd_image_t m;
    m = '0;
    m.structure_version_code = t[1:0];
    m.spec_version = t[5:2];
    m.async_access_time = {1'b0, t[14:8]};
    m.clocked_access_cycles = t[23:16];
    m.transfer_rate = (t[5:2] >= 4'h4) ? 8'h2A : {1'b0, t[30:24]};
    m.command_class_mask = f[11:0];
    m.read_block_bytes_exp = f[15:12];
    m.partial_read_allowed = f[16];
    m.write_boundary_cross_ok = f[17];
    m.read_boundary_cross_ok = f[18];
    m.driver_stage_present = f[19];
    m.device_size = p[11:0];
    m.read_current_low_supply = p[14:12];
    m.read_current_high_supply = p[17:15];
    m.write_current_low_supply = p[20:18];
    m.write_current_high_supply = p[23:21];
    m.device_size_scale = p[26:24];
    return m;
  endfunction : exp_img

  function automatic logic [31:0] exp_st(logic [31:0] t, logic [31:0] f,
      logic hs);
    exp_st = '0;
    exp_st[0] = t[1:0] == 2'h3;
    exp_st[1] = t[5:2] >= 4'h5;
    exp_st[2] = t[14:11] == 4'h0;
    exp_st[3] = t[26:24] >= 3'h4;
    exp_st[4] = t[30:27] == 4'h0;
    exp_st[5] = f[15:12] >= 4'hC;
    exp_st[6] = f[23:20] >= 4'hC;
    exp_st[7] = t[5:2] >= 4'h4 && t[31:24] != 8'h2A;
    exp_st[8] = !hs;
  endfunction : exp_st

  // Monitor: oldest note against each completed transfer
  always @(posedge clk_sys) begin
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      chk(pslverr, e[32]);
      if (e[33]) begin
        chk(prdata, e[31:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h3847;
    {psel, penable, pwrite, hs_mode} = 4'h0;
    paddr = '0;
    pwdata = '0;
    resetn = 1'b0;
    drv_exp = csfd_pkg::DRIVER_RST;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    t = csfd_pkg::TIMING_RST;
    f = csfd_pkg::FORMAT_RST;
    p = csfd_pkg::POWER_RST;
    rd(csfd_pkg::OFS_TIMING, t);
    rd(csfd_pkg::OFS_FORMAT, f);
    rd(csfd_pkg::OFS_POWER, p);
    rd(csfd_pkg::OFS_STATUS, exp_st(t, f, 1'b0));
    rd(csfd_pkg::OFS_DRIVER, '0);
    cmp_img(exp_img(t, f, p));
    for (i = 0; i < 20; i++) begin
      w = $random(seed);
      w[5:0] = {i[3:0], i[1:0]};
      w[14:11] = i[3:0];
      if (i >= 16) w[30:24] = {i[3:0], 1'b1, i[1:0]};
      else if (i >= 4) w[30:24] = {w[30:27] | 4'h1, 1'b0, w[25:24]};
      t = w & TMASK;
      wr(csfd_pkg::OFS_TIMING, w);
      cmp_img(exp_img(t, f, p));
      chk(img[80:79], t[1:0]);
      chk(nac, 32'(t[23:16]) * 32'h64);
      rd(csfd_pkg::OFS_STATUS, exp_st(t, f, hs_mode));
      if (i < 4 || i >= 16) rd(csfd_pkg::OFS_TIMING, t);
    end
    for (i = 0; i < 16; i++) begin
      w = $random(seed);
      w[23:12] = {~i[3:0], w[19:17], i[0], i[3:0]};
      f = w & 32'h00FF_FFFF;
      wr(csfd_pkg::OFS_FORMAT, w);
      cmp_img(exp_img(t, f, p));
      rd(csfd_pkg::OFS_FORMAT, f);
      rd(csfd_pkg::OFS_STATUS, exp_st(t, f, hs_mode));
      w = $random(seed);
      if (f[19]) drv_exp = w[15:0];
      wr(csfd_pkg::OFS_DRIVER, w);
      #1;
      chk(drv_stage, drv_exp);
      chk(drv_present, f[19]);
      rd(csfd_pkg::OFS_DRIVER, f[19] ? {16'h0, drv_exp} : '0);
    end
    t = csfd_pkg::TIMING_RST;
    f = csfd_pkg::FORMAT_RST;
    wr(csfd_pkg::OFS_TIMING, t);
    wr(csfd_pkg::OFS_FORMAT, f);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      hs_mode <= i[0];
      w = $random(seed);
      w[26:24] = i[2:0];
      p = w & 32'h07FF_FFFF;
      wr(csfd_pkg::OFS_POWER, w);
      cmp_img(exp_img(t, f, p));
      rd(csfd_pkg::OFS_POWER, p);
      rd(csfd_pkg::OFS_STATUS, exp_st(t, f, i[0]));
      chk(capacity, ((64'(p[11:0]) + 64'h1) << (i + 2)) << f[15:12]);
      chk(cur_valid, !i[0]);
    end
    // Refused accesses leave status, timing and power as they were
    wr(csfd_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rd(csfd_pkg::OFS_STATUS, exp_st(t, f, hs_mode));
    apb(1'b1, 12'h014, 32'hFFFF_FFFF, 1'b1, 1'b0, '0);
    apb(1'b0, 12'h7FC, '0, 1'b1, 1'b0, '0);
    rd(csfd_pkg::OFS_TIMING, t);
    rd(csfd_pkg::OFS_POWER, p);
    @(posedge clk_sys);
    chk(exp_q.size(), 0);
    complete_run();
  end
endmodule : tb
